// [sdt_pkg.sv]
// shared constants and carriers for the switch delay timer family
// assumes a 100 MHz system clock and one logic cycle per 10 ms tick
`default_nettype none
package sdt_pkg;
  localparam int unsigned SDT_CLK_HZ = 100000000;
  localparam int unsigned SDT_TICK_MS = 10;
  localparam int unsigned SDT_TICK_CYC = SDT_CLK_HZ / 1000 * SDT_TICK_MS;
  localparam int unsigned SDT_FIX_MAX_S = 300;
  localparam int unsigned SDT_AOFF_MAX_S = 600;
  localparam int unsigned SDT_AON_MAX_S = 300;
  localparam int unsigned SDT_FIX_MAX_T = SDT_FIX_MAX_S * 1000 / SDT_TICK_MS;
  localparam int unsigned SDT_AOFF_MAX_T = SDT_AOFF_MAX_S * 1000 / SDT_TICK_MS;
  localparam int unsigned SDT_AON_MAX_T = SDT_AON_MAX_S * 1000 / SDT_TICK_MS;
  localparam int SDT_TW = 17;
  typedef logic [SDT_TW-1:0] sdt_time_t;
  localparam sdt_time_t SDT_TIME_RST = 17'h00000;
  typedef struct packed {
    logic ctrl;
    logic [3:0] dly;
  } sdt_in_s;
  typedef struct packed {
    sdt_time_t t3;
    sdt_time_t t2;
    sdt_time_t t1;
    sdt_time_t t0;
  } sdt_cfg4_s;
  typedef struct packed {
    logic release_out;
    logic time_change;
  } sdt_out_s;
endpackage
`default_nettype wire

// [sdt_src.sv]
// partner model: upstream logic blocks feeding control and delay levels
// assumes the bench sets wanted levels just after a logic tick
`timescale 1ns/10ps
`default_nettype none
module sdt_src
(
  // clock
  input wire logic clk_sys,
  // wanted levels {foff, fon, aoff, aon}
  input wire logic [11:0] want,
  // driven levels
  output logic foff_ctrl,
  output logic fon_ctrl,
  output sdt_pkg::sdt_in_s aoff_in,
  output sdt_pkg::sdt_in_s aon_in
);
  initial {foff_ctrl, fon_ctrl, aoff_in, aon_in} = 12'h000;
  // levels change just after a clock edge, like a registered logic block
  always @(posedge clk_sys)
  begin
    {foff_ctrl, fon_ctrl, aoff_in, aon_in} <= want;
  end
endmodule // sdt_src
`default_nettype wire

// [sdt_timers.sv]
// switch delay timers: fixed off/on delay and adjustable off/on delay
// assumes inputs come from unrelated logic (synchronised here) and
// configuration is held stable by the configuring party
//
// How it works
// - fixed off-delay starts on a falling input and drops release when time runs out if still low.
// - off-delay timers force release high and clear the count while running with the control high.
// - fixed times run from zero to 300 s in 10 ms ticks.
// - adjustable timers sum the configured times whose delay input is set.
// - adjustable off-delay times run to 600 s each and their sum is capped at 600 s.
// - an off-delay input counts only when its configured time is nonzero.
// - adjustable off-delay starts on a falling control and drops release after the sum if still low.
// - adjustable off-delay latches the delay inputs at the falling edge.
// - a delay input change during a sequence sets time change until control returns to idle level or run stops.
// - a low off-delay control in the first run cycle keeps release low with no delay.
// - fixed on-delay starts on a rising input and raises release when time runs out if still high.
// - on-delay timers force release low and clear the count while the control is low.
// - adjustable on-delay starts on a rising control, raises release after the sum, 300 s per time.
// - adjustable on-delay latches the delay inputs at the rising edge.
// - a high on-delay control in the first run cycle raises release at once.
`timescale 1ns/10ps
`default_nettype none
module sdt_timers
#(
  parameter int unsigned TICK_CYC = sdt_pkg::SDT_TICK_CYC
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controller state: high while running
  input wire logic run,
  // control and delay inputs
  input wire logic foff_ctrl,
  input wire logic fon_ctrl,
  input wire sdt_pkg::sdt_in_s aoff_in,
  input wire sdt_pkg::sdt_in_s aon_in,
  // configured times in 10 ms ticks
  input wire sdt_pkg::sdt_time_t foff_time,
  input wire sdt_pkg::sdt_time_t fon_time,
  input wire sdt_pkg::sdt_cfg4_s aoff_cfg,
  input wire sdt_pkg::sdt_cfg4_s aon_cfg,
  // results
  output logic foff_release,
  output logic fon_release,
  output sdt_pkg::sdt_out_s aoff_out,
  output sdt_pkg::sdt_out_s aon_out,
  output logic logic_tick
);
  ////////////////////////////////////////////////////////////////////////
  // helpers
  localparam int SDT_W = sdt_pkg::SDT_TW + 2;
  function automatic sdt_pkg::sdt_time_t clip(input logic [SDT_W-1:0] v, input int unsigned mx);
    logic [SDT_W-1:0] m;
    m = SDT_W'(mx);
    clip = (v > m) ? sdt_pkg::sdt_time_t'(m) : sdt_pkg::sdt_time_t'(v);
  endfunction
  function automatic sdt_pkg::sdt_time_t sum4(input sdt_pkg::sdt_cfg4_s c, input logic [3:0] en,
                                               input int unsigned each, input int unsigned tot);
    logic [SDT_W-1:0] s;
    s = '0;
    if (en[0]) s = s + SDT_W'(clip(SDT_W'(c.t0), each));
    if (en[1]) s = s + SDT_W'(clip(SDT_W'(c.t1), each));
    if (en[2]) s = s + SDT_W'(clip(SDT_W'(c.t2), each));
    if (en[3]) s = s + SDT_W'(clip(SDT_W'(c.t3), each));
    sum4 = clip(s, tot);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // synchronisers and logic-cycle tick
  localparam int NS = 13;
  logic [NS-1:0] raw, s1_q, s2_q, smp_q, prv_q;
  logic first_q;
  logic [31:0] div_q;
  logic tick_q;
  assign raw = {run, foff_ctrl, fon_ctrl, aoff_in, aon_in};
  wire tick_now = (div_q == TICK_CYC - 1);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      div_q <= tick_now ? 32'h00000000 : div_q + 32'h00000001;
      tick_q <= tick_now;
    end
  end
  // sampled views, one per logic cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      smp_q <= '0;
      prv_q <= '0;
      first_q <= 1'b0;
    end
    else if (tick_q)
    begin
      smp_q <= s2_q;
      prv_q <= smp_q;
      first_q <= s2_q[12] & ~smp_q[12];
    end
  end
  wire run_ok = smp_q[12];
  wire foff_c = smp_q[11], foff_p = prv_q[11];
  wire fon_c = smp_q[10], fon_p = prv_q[10];
  wire aoff_c = smp_q[9], aoff_p = prv_q[9];
  wire [3:0] aoff_d = smp_q[8:5], aoff_dp = prv_q[8:5];
  wire aon_c = smp_q[4], aon_p = prv_q[4];
  wire [3:0] aon_d = smp_q[3:0], aon_dp = prv_q[3:0];
  // one step strobe, one cycle after the sample update
  logic step_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst) step_q <= 1'b0;
    else step_q <= tick_q;
  end
  ////////////////////////////////////////////////////////////////////////
  // timer channel state: count remaining, running flag
  // index 0 foff, 1 fon, 2 aoff, 3 aon
  sdt_pkg::sdt_time_t cnt_q [4];
  logic [3:0] act_q, rel_q;
  logic [1:0] tc_q;
  wire [3:0] ctrl_c = {aon_c, aoff_c, fon_c, foff_c};
  wire [3:0] ctrl_p = {aon_p, aoff_p, fon_p, foff_p};
  wire [3:0] is_off = 4'b0101;
  // zero off-delay times never count as activated, for the sum and for time change
  wire [3:0] aoff_msk = {|aoff_cfg.t3, |aoff_cfg.t2, |aoff_cfg.t1, |aoff_cfg.t0};
  wire [3:0] aoff_en = aoff_d & aoff_msk;
  sdt_pkg::sdt_time_t start_t [4];
  assign start_t[0] = clip(SDT_W'(foff_time), sdt_pkg::SDT_FIX_MAX_T);
  assign start_t[1] = clip(SDT_W'(fon_time), sdt_pkg::SDT_FIX_MAX_T);
  assign start_t[2] = sum4(aoff_cfg, aoff_en, sdt_pkg::SDT_AOFF_MAX_T,
                           sdt_pkg::SDT_AOFF_MAX_T);
  assign start_t[3] = sum4(aon_cfg, aon_d, sdt_pkg::SDT_AON_MAX_T,
                           sdt_pkg::SDT_AON_MAX_T * 4);
  wire [3:0] dchg = {|(aon_d ^ aon_dp), |((aoff_d ^ aoff_dp) & aoff_msk), 2'b00};
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      // idle level: high for off-delay, low for on-delay
      wire idle = is_off[g] ? ctrl_c[g] : ~ctrl_c[g];
      wire trig = is_off[g] ? (ctrl_p[g] & ~ctrl_c[g]) : (~ctrl_p[g] & ctrl_c[g]);
      wire held = is_off[g] ? 1'b1 : 1'b0;
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          cnt_q[g] <= sdt_pkg::SDT_TIME_RST;
          act_q[g] <= 1'b0;
          rel_q[g] <= 1'b0;
        end
        else if (step_q)
        begin
          if (!run_ok)
          begin
            cnt_q[g] <= sdt_pkg::SDT_TIME_RST;
            act_q[g] <= 1'b0;
            rel_q[g] <= 1'b0;
          end
          else if (idle)
          begin
            cnt_q[g] <= sdt_pkg::SDT_TIME_RST;
            act_q[g] <= 1'b0;
            rel_q[g] <= held;
          end
          else if (first_q)
          begin
            act_q[g] <= 1'b0;
            rel_q[g] <= ~held;
          end
          else if (trig)
          begin
            if (start_t[g] <= sdt_pkg::sdt_time_t'(1))
            begin
              act_q[g] <= 1'b0;
              rel_q[g] <= ~held;
            end
            else
            begin
              cnt_q[g] <= start_t[g] - sdt_pkg::sdt_time_t'(1);
              act_q[g] <= 1'b1;
            end
          end
          else if (act_q[g])
          begin
            if (cnt_q[g] <= sdt_pkg::sdt_time_t'(1))
            begin
              act_q[g] <= 1'b0;
              rel_q[g] <= ~held;
            end
            else
              cnt_q[g] <= cnt_q[g] - sdt_pkg::sdt_time_t'(1);
          end
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // time change flags, set wins while the sequence runs
  generate
    for (g = 2; g < 4; g++)
    begin : g_tc
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst) tc_q[g-2] <= 1'b0;
        else if (step_q)
        begin
          if (act_q[g] && dchg[g]) tc_q[g-2] <= 1'b1;
          else if (g_ch[g].idle || !run_ok) tc_q[g-2] <= 1'b0;
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      foff_release <= 1'b0;
      fon_release <= 1'b0;
      aoff_out <= '0;
      aon_out <= '0;
      logic_tick <= 1'b0;
    end
    else
    begin
      foff_release <= rel_q[0];
      fon_release <= rel_q[1];
      aoff_out <= '{release_out: rel_q[2], time_change: tc_q[0]};
      aon_out <= '{release_out: rel_q[3], time_change: tc_q[1]};
      logic_tick <= step_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  a_off_idle_high: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && foff_c) |=> ##1 foff_release) else $error("off release not high");
  a_on_idle_low: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && fon_c == 1'b0) |=> ##1 !fon_release) else $error("on release not low");
  a_aoff_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && aoff_c && !first_q) |=> ##1 aoff_out.release_out)
    else $error("adj off release not high");
  a_aon_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && !aon_c) |=> ##1 !aon_out.release_out) else $error("adj on release not low");
  a_tc_set: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && act_q[2] && dchg[2]) |=> ##1 aoff_out.time_change)
    else $error("time change not set");
  a_tc_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && aon_c == 1'b0 && !act_q[3]) |=> ##1 !aon_out.time_change)
    else $error("time change not cleared");
  a_on_start: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && !first_q && !fon_p && fon_c && start_t[1] > 17'h00001)
    |=> act_q[1] && cnt_q[1] == $past(start_t[1]) - 17'h00001)
    else $error("on timer bad start");
  a_off_start: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && !first_q && foff_p && !foff_c && start_t[0] > 17'h00001)
    |=> act_q[0] && $stable(rel_q[0])) else $error("off timer bad start");
  a_stop_clears: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && !run_ok) |=> ##1 !foff_release && !aoff_out.release_out)
    else $error("release set while stopped");
  a_fon_first_high: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && first_q && fon_c) |=> rel_q[1])
    else $error("on release not raised at run start");
  a_aon_first_high: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && first_q && aon_c) |=> rel_q[3])
    else $error("adj on release not raised at run start");
  a_foff_first_low: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && first_q && !foff_c) |=> !rel_q[0] && !act_q[0])
    else $error("off release not held low at run start");
  a_aoff_first_low: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && first_q && !aoff_c) |=> !rel_q[2] && !act_q[2])
    else $error("adj off release not held low at run start");
  a_fix_time_cap: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_q[0] < sdt_pkg::sdt_time_t'(sdt_pkg::SDT_FIX_MAX_T)
    && cnt_q[1] < sdt_pkg::sdt_time_t'(sdt_pkg::SDT_FIX_MAX_T))
    else $error("fixed delay over range");
  a_aoff_sum_cap: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_q[2] < sdt_pkg::sdt_time_t'(sdt_pkg::SDT_AOFF_MAX_T))
    else $error("adj off delay over range");
  a_aon_sum_cap: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_q[3] < sdt_pkg::sdt_time_t'(sdt_pkg::SDT_AON_MAX_T * 4))
    else $error("adj on delay over range");
  a_fon_zero_pass: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && !first_q && !fon_p && fon_c && start_t[1] == 17'h00000)
    |=> rel_q[1] && !act_q[1]) else $error("zero delay not immediate");
  a_aoff_start: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && !first_q && aoff_p && !aoff_c && start_t[2] > 17'h00001)
    |=> act_q[2] && cnt_q[2] == $past(start_t[2]) - 17'h00001) else $error("adj off bad start");
  a_aon_start: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && !first_q && !aon_p && aon_c && start_t[3] > 17'h00001)
    |=> act_q[3] && cnt_q[3] == $past(start_t[3]) - 17'h00001) else $error("adj on bad start");
  a_aoff_count: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && act_q[2] && !aoff_c && cnt_q[2] > 17'h00001)
    |=> cnt_q[2] == $past(cnt_q[2]) - 17'h00001) else $error("adj off count disturbed");
  a_aon_count: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && act_q[3] && aon_c && cnt_q[3] > 17'h00001)
    |=> cnt_q[3] == $past(cnt_q[3]) - 17'h00001) else $error("adj on count disturbed");
  a_tc_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && tc_q[0] && !aoff_c) |=> tc_q[0])
    else $error("time change dropped early");
  a_fon_expiry: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && act_q[1] && fon_c && cnt_q[1] <= 17'h00001)
    |=> rel_q[1] && !act_q[1]) else $error("on timer missed expiry");
  a_foff_expiry: assert property (@(posedge clk_sys) disable iff (rst)
    (step_q && run_ok && act_q[0] && !foff_c && cnt_q[0] <= 17'h00001)
    |=> !rel_q[0] && !act_q[0]) else $error("off timer missed expiry");
endmodule // sdt_timers
`default_nettype wire

// [sdt_timers_bench.sv]
// testbench for the switch delay timers with a short logic cycle
// assumes the partner model drives control and delay levels
`timescale 1ns/10ps
`default_nettype none
module sdt_timers_bench;
  localparam int unsigned TCYC = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic foff_w = 1'b0;
  logic fon_w = 1'b0;
  sdt_pkg::sdt_in_s aoff_w = '0;
  sdt_pkg::sdt_in_s aon_w = '0;
  sdt_pkg::sdt_time_t foff_time = 17'h00003;
  sdt_pkg::sdt_time_t fon_time = 17'h00005;
  sdt_pkg::sdt_cfg4_s aoff_cfg = {17'h00005, 17'h00000, 17'h00003, 17'h00002};
  sdt_pkg::sdt_cfg4_s aon_cfg = {17'h00004, 17'h00000, 17'h00002, 17'h00001};
  logic foff_ctrl;
  logic fon_ctrl;
  sdt_pkg::sdt_in_s aoff_in;
  sdt_pkg::sdt_in_s aon_in;
  logic foff_release;
  logic fon_release;
  sdt_pkg::sdt_out_s aoff_out;
  sdt_pkg::sdt_out_s aon_out;
  logic logic_tick;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  sdt_src src (.clk_sys(clk_sys), .want({foff_w, fon_w, aoff_w, aon_w}),
    .foff_ctrl(foff_ctrl), .fon_ctrl(fon_ctrl), .aoff_in(aoff_in), .aon_in(aon_in));
  sdt_timers #(.TICK_CYC(TCYC)) dut (.clk_sys(clk_sys), .rst(rst), .run(run),
    .foff_ctrl(foff_ctrl), .fon_ctrl(fon_ctrl), .aoff_in(aoff_in), .aon_in(aon_in),
    .foff_time(foff_time), .fon_time(fon_time), .aoff_cfg(aoff_cfg), .aon_cfg(aon_cfg),
    .foff_release(foff_release), .fon_release(fon_release), .aoff_out(aoff_out),
    .aon_out(aon_out), .logic_tick(logic_tick));
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t %s", $time, what);
      err_count++;
    end
  endtask
  // wait for n output updates; outputs change on the clock edge that ends the logic_tick pulse, one cycle after it rises
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      while (logic_tick !== 1'b1)
        @(negedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  task automatic t_tick();
    int n;
    n = 0;
    ticks(1);
    while (logic_tick !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(4'(n), 4'(TCYC - 1), "tick period");
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      $display("ERROR t=%0t timeout", $time);
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_first_run();
    foff_w = 1'b1;
    aoff_w = {1'b1, 4'h0};
    repeat (4 * TCYC) @(negedge clk_sys);
    chk({foff_release, fon_release, aoff_out.release_out, aon_out.release_out}, 4'h0, "stop");
    foff_w = 1'b0;
    fon_w = 1'b1;
    aoff_w = {1'b0, 4'h0};
    aon_w = {1'b1, 4'h8};
    repeat (4 * TCYC) @(negedge clk_sys);
    run = 1'b1;
    ticks(2);
    chk({foff_release, fon_release, aoff_out.release_out, aon_out.release_out}, 4'h5, "run");
  endtask
  task automatic t_foff();
    foff_w = 1'b1;
    ticks(1);
    chk({3'h0, foff_release}, 4'h1, "foff high");
    foff_w = 1'b0;
    ticks(2);
    chk({3'h0, foff_release}, 4'h1, "foff early");
    foff_w = 1'b1;
    ticks(1);
    foff_w = 1'b0;
    ticks(2);
    chk({3'h0, foff_release}, 4'h1, "foff restart");
    ticks(1);
    chk({3'h0, foff_release}, 4'h0, "foff expiry");
  endtask
  task automatic t_fon();
    fon_w = 1'b0;
    ticks(1);
    chk({3'h0, fon_release}, 4'h0, "fon low");
    fon_time = 17'h00002;
    fon_w = 1'b1;
    ticks(1);
    chk({3'h0, fon_release}, 4'h0, "fon early");
    ticks(1);
    chk({3'h0, fon_release}, 4'h1, "fon expiry");
    fon_w = 1'b0;
    ticks(1);
    fon_time = 17'h00000;
    fon_w = 1'b1;
    ticks(1);
    chk({3'h0, fon_release}, 4'h1, "fon zero");
  endtask
  task automatic t_aoff();
    aoff_w = {1'b1, 4'hb};
    ticks(1);
    aoff_w = {1'b0, 4'hb};
    ticks(1);
    chk({2'h0, aoff_out}, 4'h2, "aoff start");
    aoff_w = {1'b0, 4'hf};
    ticks(1);
    chk({2'h0, aoff_out}, 4'h2, "aoff zero input");
    aoff_w = {1'b0, 4'h3};
    ticks(1);
    chk({2'h0, aoff_out}, 4'h3, "aoff change");
    ticks(6);
    chk({2'h0, aoff_out}, 4'h3, "aoff latched");
    ticks(1);
    chk({2'h0, aoff_out}, 4'h1, "aoff expiry");
    aoff_w = {1'b1, 4'h3};
    ticks(1);
    chk({2'h0, aoff_out}, 4'h2, "aoff clear");
  endtask
  task automatic t_aon();
    aon_w = {1'b0, 4'h3};
    ticks(1);
    chk({2'h0, aon_out}, 4'h0, "aon low");
    aon_w = {1'b1, 4'h3};
    ticks(1);
    aon_w = {1'b1, 4'hb};
    ticks(1);
    chk({2'h0, aon_out}, 4'h1, "aon change");
    ticks(1);
    chk({2'h0, aon_out}, 4'h3, "aon expiry");
    aon_w = {1'b0, 4'hb};
    ticks(1);
    chk({2'h0, aon_out}, 4'h0, "aon clear");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // configured times run from zero to five logic cycles
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    t_first_run();
    t_foff();
    t_fon();
    t_aoff();
    t_aon();
    t_tick();
    close_out();
  end
endmodule // sdt_timers_bench
`default_nettype wire
